// File: rtl/ccu_compare_unit.sv
// Purpose: compare instruction group, sets only the condition code
// Assumes: i_start is taken only while o_busy is low; memory word arrives on i_mem_valid
// Notes:   operands are sampled, so the register file may move during a compare
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"

module ccu_compare_unit (
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_start,
	input  wire ccu_pkg::ccu_word_t i_instr,
	input  wire ccu_pkg::ccu_gpr_t  i_regs,
	input  wire logic               i_mem_valid,
	input  wire ccu_pkg::ccu_word_t i_mem_word,
	output ccu_pkg::ccu_mem_req_t   o_mem_req,
	output ccu_pkg::ccu_cc_t        o_cc,
	output logic                    o_cc_we,
	output logic                    o_busy,
	output logic                    o_illegal
);

	////////////////////////////////////////////////////////////////
	// helpers

	function automatic ccu_pkg::ccu_word_t or_sel(input logic [5:0] sel,
		input ccu_pkg::ccu_gpr_t r);
		ccu_pkg::ccu_word_t v;
		v = '0;
		if (sel[`CCU_SEL_I]) v = v | r.i;
		if (sel[`CCU_SEL_J]) v = v | r.j;
		if (sel[`CCU_SEL_K]) v = v | r.k;
		if (sel[`CCU_SEL_E]) v = v | r.e;
		if (sel[`CCU_SEL_A]) v = v | r.a;
		if (sel[`CCU_SEL_T]) v = v | r.t;
		return v;
	endfunction

	function automatic ccu_pkg::ccu_word_t sext8(input logic [`CCU_BYTE_HI:0] b);
		return {{(`CCU_W-`CCU_BYTE_HI-1){b[`CCU_BYTE_HI]}}, b};
	endfunction

	function automatic ccu_pkg::ccu_word_t idx_reg(input logic [2:0] x,
		input ccu_pkg::ccu_gpr_t r);
		ccu_pkg::ccu_word_t v;
		v = '0;
		case (x)
			3'h1: v = r.i;
			3'h2: v = r.j;
			3'h3: v = r.k;
			default: v = '0;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////
	// decode

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC
	} ccu_state_t;

	wire logic [5:0]  opc;
	wire logic [11:0] aug;
	wire logic [17:0] hi18;
	wire logic [2:0]  xfld;
	wire logic [5:0]  r1fld;
	wire logic [5:0]  r2fld;
	wire logic        dec_idx;
	wire logic        dec_acc;
	wire logic        dec_ext;
	wire logic        dec_memb;
	wire logic        dec_imm;
	wire logic        dec_sgn_rr;
	wire logic        dec_uns_rr;
	wire logic        dec_zero;
	wire logic        dec_double;
	wire logic        dec_mem;
	wire logic        dec_any;
	wire logic        take;

	assign opc   = i_instr[`CCU_OPC_HI:`CCU_OPC_LO];
	assign aug   = i_instr[`CCU_W-1:`CCU_AUG_LO];
	assign hi18  = i_instr[`CCU_W-1:`CCU_R1_LO];
	assign xfld  = i_instr[`CCU_X_HI:`CCU_X_LO];
	assign r1fld = i_instr[`CCU_R1_HI:`CCU_R1_LO];
	assign r2fld = i_instr[`CCU_R2_HI:`CCU_R2_LO];

	// x of 0 or above 3 selects no index register, so it is not a compare
	assign dec_idx    = (opc == `CCU_OPC_MEM_IDX) && (xfld >= `CCU_X_MIN)
		&& (xfld <= `CCU_X_MAX);
	assign dec_acc    = (opc == `CCU_OPC_MEM_ACC);
	assign dec_ext    = (opc == `CCU_OPC_MEM_EXT);
	assign dec_memb   = (opc == `CCU_OPC_MEM_BYTE);
	assign dec_imm    = (aug == `CCU_AUG_IMM);
	assign dec_sgn_rr = (aug == `CCU_AUG_RR_SGN);
	assign dec_uns_rr = (aug == `CCU_AUG_RR_UNS);
	// zero compare is the signed form with an empty first field
	assign dec_zero   = (hi18 == `CCU_ZERO_BASE);
	assign dec_double = dec_zero && (r2fld == `CCU_SEL_DOUBLE);
	assign dec_mem    = dec_idx | dec_acc | dec_ext | dec_memb;
	assign dec_any    = dec_mem | dec_imm | dec_sgn_rr | dec_uns_rr;
	assign take       = i_start && !o_busy;

	////////////////////////////////////////////////////////////////
	// operand selection

	ccu_pkg::ccu_word_t reg_side;
	ccu_pkg::ccu_word_t first_rr;
	ccu_pkg::ccu_word_t mem_side;

	always_comb begin
		reg_side = or_sel(r2fld, i_regs);
		if (dec_idx)
			reg_side = idx_reg(xfld, i_regs);
		else if (dec_acc)
			reg_side = i_regs.a;
		else if (dec_ext)
			reg_side = i_regs.e;
		else if (dec_memb || dec_imm)
			reg_side = sext8(i_regs.a[`CCU_BYTE_HI:0]);
		else if (dec_double)
			reg_side = i_regs.e | i_regs.a;
	end

	// empty r1 in the zero form yields zero as first quantity
	assign first_rr = dec_imm ? sext8(i_instr[`CCU_BYTE_HI:0])
		: or_sel(r1fld, i_regs);

	ccu_pkg::ccu_kind_t kind_reg;

	assign mem_side = (kind_reg == ccu_pkg::CCU_K_MEMB)
		? sext8(i_mem_word[`CCU_BYTE_HI:0]) : i_mem_word;

	////////////////////////////////////////////////////////////////
	// sequencing

	ccu_state_t          state_reg;
	ccu_pkg::ccu_word_t  op_a_reg;
	ccu_pkg::ccu_word_t  op_b_reg;
	logic                signed_reg;
	ccu_pkg::ccu_cc_t    cmp_cc;
	ccu_pkg::ccu_kind_t  kind_next;

	always_comb begin
		kind_next = ccu_pkg::CCU_K_RR;
		if (dec_idx)
			kind_next = ccu_pkg::CCU_K_IDX;
		else if (dec_acc)
			kind_next = ccu_pkg::CCU_K_ACC;
		else if (dec_ext)
			kind_next = ccu_pkg::CCU_K_EXT;
		else if (dec_memb)
			kind_next = ccu_pkg::CCU_K_MEMB;
		else if (dec_imm)
			kind_next = ccu_pkg::CCU_K_IMM;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg  <= ST_IDLE;
			kind_reg   <= ccu_pkg::CCU_K_RR;
			op_a_reg   <= '0;
			op_b_reg   <= '0;
			signed_reg <= 1'b1;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take && dec_any) begin
						kind_reg   <= kind_next;
						op_b_reg   <= reg_side;
						op_a_reg   <= first_rr;
						signed_reg <= !dec_uns_rr;
						state_reg  <= dec_mem ? ST_FETCH : ST_EXEC;
					end
				end
				ST_FETCH: begin
					if (i_mem_valid) begin
						op_a_reg  <= mem_side;
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	ccu_mag_cmp u_cmp (
		.i_signed (signed_reg),
		.i_a      (op_a_reg),
		.i_b      (op_b_reg),
		.o_cc     (cmp_cc)
	);

	////////////////////////////////////////////////////////////////
	// outputs, all registered

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cc      <= '0;
			o_cc_we   <= 1'b0;
			o_illegal <= 1'b0;
		end else begin
			o_cc_we   <= (state_reg == ST_EXEC);
			o_illegal <= take && !dec_any;
			if (state_reg == ST_EXEC)
				o_cc <= cmp_cc;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_busy    <= 1'b0;
			o_mem_req <= '0;
		end else begin
			if (take && dec_any)
				o_busy <= 1'b1;
			else if (state_reg == ST_EXEC)
				o_busy <= 1'b0;
			if (take && dec_mem) begin
				o_mem_req.req             <= 1'b1;
				o_mem_req.indirect        <= i_instr[`CCU_IND_BIT];
				// x of the index compare names the register, not an index
				o_mem_req.index_sel       <= dec_idx ? 3'h0 : xfld;
				o_mem_req.direct_index_en <= !dec_idx;
			end else if (state_reg == ST_FETCH && i_mem_valid) begin
				o_mem_req <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	property p_cc_onehot;
		@(posedge i_clk) disable iff (!i_rst_n)
		o_cc_we |-> $onehot(o_cc);
	endproperty
	a_cc_onehot: assert property (p_cc_onehot) else $error("code not one-hot");

	property p_cc_signed;
		@(posedge i_clk) disable iff (!i_rst_n)
		(o_cc_we && signed_reg) |-> (o_cc.pos == ($signed(op_b_reg) > $signed(op_a_reg)))
			&& (o_cc.neg == ($signed(op_b_reg) < $signed(op_a_reg)));
	endproperty
	a_cc_signed: assert property (p_cc_signed) else $error("signed order wrong");

	property p_cc_unsigned;
		@(posedge i_clk) disable iff (!i_rst_n)
		(o_cc_we && !signed_reg) |-> (o_cc.pos == (op_b_reg > op_a_reg))
			&& (o_cc.zero == (op_b_reg == op_a_reg));
	endproperty
	a_cc_unsigned: assert property (p_cc_unsigned) else $error("unsigned order wrong");

	property p_idx_nodirect;
		@(posedge i_clk) disable iff (!i_rst_n)
		(take && dec_idx) |=> o_mem_req.req && !o_mem_req.direct_index_en;
	endproperty
	a_idx_nodirect: assert property (p_idx_nodirect) else $error("direct ref indexed");

	property p_acc_operand;
		@(posedge i_clk) disable iff (!i_rst_n)
		(take && dec_acc) |=> (op_b_reg == $past(i_regs.a)) && signed_reg;
	endproperty
	a_acc_operand: assert property (p_acc_operand) else $error("accumulator not taken");

	property p_imm_byte;
		@(posedge i_clk) disable iff (!i_rst_n)
		(take && dec_imm) |=> (op_a_reg == sext8($past(i_instr[`CCU_BYTE_HI:0])))
			##1 o_cc_we;
	endproperty
	a_imm_byte: assert property (p_imm_byte) else $error("immediate byte compare");

	property p_zero_double;
		@(posedge i_clk) disable iff (!i_rst_n)
		(take && dec_double) |=> (op_a_reg == '0)
			&& (op_b_reg == ($past(i_regs.e) | $past(i_regs.a)));
	endproperty
	a_zero_double: assert property (p_zero_double) else $error("double zero compare");

	property p_mem_wait;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_reg == ST_FETCH && !i_mem_valid) |=> !o_cc_we && o_mem_req.req;
	endproperty
	a_mem_wait: assert property (p_mem_wait) else $error("finished without memory");

	property p_cc_only_at_end;
		@(posedge i_clk) disable iff (!i_rst_n)
		$changed(o_cc) |-> o_cc_we && $past(state_reg == ST_EXEC);
	endproperty
	a_cc_only_at_end: assert property (p_cc_only_at_end) else $error("code moved early");

	property p_reg_latency;
		@(posedge i_clk) disable iff (!i_rst_n)
		(take && (dec_sgn_rr || dec_uns_rr)) |=> o_busy ##1 o_cc_we;
	endproperty
	a_reg_latency: assert property (p_reg_latency) else $error("register compare late");

endmodule

`default_nettype wire

// File: rtl/ccu_defines.svh
// Purpose: constants of the compare condition unit
// Assumes: 24-bit words, octal opcodes written here as hex literals
// Notes:   how it works, listed below
//
// How it works
// - every compare forms second minus first; code is positive, negative or zero
// - algebraic compares are signed, logical compares treat operands as unsigned
// - opcode 31 signed-compares memory with index register 1, 2 or 3
// - memory-versus-index compare never indexes the direct reference, only indirect words
// - opcode 33 signed-compares memory word with the accumulator
// - opcode 32 signed-compares memory word with the extension register
// - opcode 0014 signed-compares 8-bit instruction operand with accumulator low byte
// - opcode 34 signed-compares memory low byte with accumulator low byte
// - compare-with-zero is 002400 plus one-hot field 01,02,04,10,20,40
// - compare-with-zero signed-compares the selected register against zero
// - several selected registers are ORed first; selecting none is legal
// - 00240030 ORs extension and accumulator, then signed-compares with zero
// - opcode 0025 with two one-hot fields compares them unsigned
// - opcode 0024 with two one-hot fields compares them signed
// - each register-to-register field ORs all registers it selects
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

`define CCU_W            24
`define CCU_OPC_HI       23
`define CCU_OPC_LO       18
`define CCU_IND_BIT      17
`define CCU_X_HI         16
`define CCU_X_LO         14
`define CCU_AUG_LO       12
`define CCU_R1_HI        11
`define CCU_R1_LO        6
`define CCU_R2_HI        5
`define CCU_R2_LO        0
`define CCU_BYTE_HI      7

`define CCU_OPC_MEM_IDX  6'h19
`define CCU_OPC_MEM_EXT  6'h1a
`define CCU_OPC_MEM_ACC  6'h1b
`define CCU_OPC_MEM_BYTE 6'h1c
`define CCU_AUG_IMM      12'h00c
`define CCU_AUG_RR_SGN   12'h014
`define CCU_AUG_RR_UNS   12'h015
`define CCU_ZERO_BASE    18'h00500
`define CCU_SEL_DOUBLE   6'h18
`define CCU_X_MIN        3'h1
`define CCU_X_MAX        3'h3

`define CCU_SEL_I        0
`define CCU_SEL_J        1
`define CCU_SEL_K        2
`define CCU_SEL_E        3
`define CCU_SEL_A        4
`define CCU_SEL_T        5

`endif

// File: rtl/ccu_pkg.sv
// Purpose: types shared by the compare condition unit
// Assumes: constants come from ccu_defines.svh
// Notes:   no numbers live here
`include "ccu_defines.svh"

package ccu_pkg;

	typedef logic [`CCU_W-1:0] ccu_word_t;

	typedef struct packed {
		logic pos;
		logic neg;
		logic zero;
	} ccu_cc_t;

	typedef struct packed {
		ccu_word_t t;
		ccu_word_t a;
		ccu_word_t e;
		ccu_word_t k;
		ccu_word_t j;
		ccu_word_t i;
	} ccu_gpr_t;

	typedef struct packed {
		logic       req;
		logic       indirect;
		logic [2:0] index_sel;
		logic       direct_index_en;
	} ccu_mem_req_t;

	typedef enum logic [2:0] {
		CCU_K_IDX,
		CCU_K_ACC,
		CCU_K_EXT,
		CCU_K_MEMB,
		CCU_K_IMM,
		CCU_K_RR
	} ccu_kind_t;

endpackage

// File: rtl/ccu_mag_cmp.sv
// Purpose: signed or unsigned magnitude compare into a condition code
// Assumes: a is the first quantity, b the second
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"

module ccu_mag_cmp (
	input  wire logic              i_signed,
	input  wire ccu_pkg::ccu_word_t i_a,
	input  wire ccu_pkg::ccu_word_t i_b,
	output ccu_pkg::ccu_cc_t        o_cc
);

	// flipping the sign bit turns a signed order into an unsigned one
	wire logic [`CCU_W-1:0] a_adj;
	wire logic [`CCU_W-1:0] b_adj;

	assign a_adj = {i_a[`CCU_W-1] ^ i_signed, i_a[`CCU_W-2:0]};
	assign b_adj = {i_b[`CCU_W-1] ^ i_signed, i_b[`CCU_W-2:0]};

	// one driver for the whole code: pos, neg, zero
	assign o_cc = {(b_adj > a_adj), (b_adj < a_adj), (a_adj == b_adj)};

endmodule

`default_nettype wire

// File: tb/ccu_mem_model.sv
// Purpose: memory operand fetch path model for the compare unit
// Assumes: one fetch per request, request held until the word is seen
// Notes:   delay is set per fetch so replies come prompt or slow
`timescale 1ns/1ps
`default_nettype none

module ccu_mem_model (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire ccu_pkg::ccu_mem_req_t i_req,
	input  wire ccu_pkg::ccu_word_t    i_word,
	input  wire logic [3:0]            i_delay,
	output logic                       o_valid,
	output ccu_pkg::ccu_word_t         o_word
);
	logic [3:0] cnt_reg;
	logic       served_reg;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= 4'h0;
			served_reg <= 1'b0;
			o_valid <= 1'b0;
			o_word <= 24'h0;
		end else begin
			o_valid <= 1'b0;
			// outside the valid cycle the bus keeps toggling, never a stale word
			o_word <= ~o_word;
			if (!i_req.req) begin
				cnt_reg <= 4'h0;
				served_reg <= 1'b0;
			end else if (!served_reg) begin
				// request stays up one edge after the word: answer once only
				if (cnt_reg == i_delay) begin
					o_valid <= 1'b1;
					o_word <= i_word;
					served_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 4'h1;
				end
			end
		end
	end
endmodule

`default_nettype wire

// File: tb/ccu_compare_unit_test.sv
// Purpose: self-checking bench for the compare unit
// Assumes: octal opcodes and field layout of ccu_defines.svh
// Notes:   random registers and words from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"

module ccu_compare_unit_test;
	logic                  i_clk;
	logic                  i_rst_n;
	logic                  i_start;
	logic                  mem_valid;
	logic [3:0]            mdly;
	logic [7:0]            op;
	logic [5:0]            r1;
	logic [5:0]            r2;
	logic [2:0]            x;
	logic                  ind;
	ccu_pkg::ccu_word_t    i_instr;
	ccu_pkg::ccu_word_t    mem_word;
	ccu_pkg::ccu_word_t    mword;
	ccu_pkg::ccu_word_t    sec;
	ccu_pkg::ccu_gpr_t     i_regs;
	ccu_pkg::ccu_gpr_t     rv;
	ccu_pkg::ccu_mem_req_t o_mem_req;
	ccu_pkg::ccu_cc_t      o_cc;
	logic                  o_cc_we;
	logic                  o_busy;
	logic                  o_illegal;
	int                    err_count;
	int                    n_tests;

	ccu_compare_unit u_ccu_compare_unit (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_instr(i_instr),
		.i_regs(i_regs), .i_mem_valid(mem_valid), .i_mem_word(mem_word),
		.o_mem_req(o_mem_req), .o_cc(o_cc), .o_cc_we(o_cc_we), .o_busy(o_busy),
		.o_illegal(o_illegal));
	ccu_mem_model u_ccu_mem_model (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(o_mem_req), .i_word(mword),
		.i_delay(mdly), .o_valid(mem_valid), .o_word(mem_word));

	always #4 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////
	function automatic ccu_pkg::ccu_word_t pick(input logic [5:0] f, input ccu_pkg::ccu_gpr_t r);
		pick = ({24{f[0]}} & r.i) | ({24{f[1]}} & r.j) | ({24{f[2]}} & r.k)
			| ({24{f[3]}} & r.e) | ({24{f[4]}} & r.a) | ({24{f[5]}} & r.t);
	endfunction

	function automatic ccu_pkg::ccu_cc_t cmp(input logic s, input ccu_pkg::ccu_word_t f,
		input ccu_pkg::ccu_word_t sc);
		logic [24:0] a;
		logic [24:0] b;
		a = {s & f[23], f};
		b = {s & sc[23], sc};
		cmp.pos = $signed(b) > $signed(a);
		cmp.neg = $signed(b) < $signed(a);
		cmp.zero = a == b;
	endfunction

	function automatic ccu_pkg::ccu_word_t sx8(input logic [7:0] v);
		sx8 = {{16{v[7]}}, v};
	endfunction

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
		n_tests++;
		if (seen !== expv) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, expv, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic rnd_regs();
		for (int b = 0; b < 6; b++) rv[b*24 +: 24] = 24'($urandom);
	endtask

	// one instruction; lat 0 skips the latency check
	task automatic run(input ccu_pkg::ccu_word_t ins, input ccu_pkg::ccu_cc_t ec,
		input ccu_pkg::ccu_mem_req_t er, input int lat);
		int n;
		ccu_pkg::ccu_cc_t held;
		@(posedge i_clk);
		i_start <= 1'b1;
		i_instr <= ins;
		i_regs <= rv;
		@(posedge i_clk);
		i_start <= 1'b0;
		held = o_cc;
		i_regs <= ~rv;
		#1;
		n = 1;
		chk("busy", o_busy, 1'b1);
		chk("mem req", o_mem_req, er);
		while (o_cc_we !== 1'b1 && n < 40) begin
			chk("cc held", o_cc, held);
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n >= 40) begin
			chk("timeout", 1'b0, 1'b1);
			conclude();
		end
		if (lat > 0) chk("latency", n, lat);
		chk("cc", o_cc, ec);
		chk("busy end", o_busy, 1'b0);
		@(posedge i_clk);
		#1;
		chk("we pulse", {o_cc_we, o_cc}, {1'b0, ec});
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		i_rst_n = 1'b0;
		i_start = 1'b0;
		i_instr = 24'h0;
		i_regs = '0;
		rv = '0;
		mword = 24'h0;
		mdly = 4'h0;
		err_count = 0;
		n_tests = 0;
		void'($urandom(86194));
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		chk("reset", {o_mem_req, o_cc, o_cc_we, o_busy, o_illegal}, 32'h0);
		for (int k = 0; k < 40; k++) begin
			rnd_regs();
			r1 = (k < 2) ? 6'h01 : 6'($urandom);
			r2 = (k < 2) ? 6'h02 : 6'($urandom);
			if (k < 2) {rv.i, rv.j} = {24'h800000, 24'h000001};
			run({k[0] ? `CCU_AUG_RR_SGN : `CCU_AUG_RR_UNS, r1, r2},
				cmp(k[0], pick(r1, rv), pick(r2, rv)), '0, 2);
		end
		for (int k = 0; k < 8; k++) begin
			rnd_regs();
			r2 = (k < 6) ? 6'(1 << k) : ((k == 6) ? 6'h00 : 6'($urandom));
			run({`CCU_ZERO_BASE, r2}, cmp(1'b1, 24'h0, pick(r2, rv)), '0, 2);
		end
		for (int k = 0; k < 3; k++) begin
			rnd_regs();
			if (k == 0) {rv.e, rv.a} = 48'h0;
			run({`CCU_ZERO_BASE, `CCU_SEL_DOUBLE}, cmp(1'b1, 24'h0, rv.e | rv.a), '0, 2);
		end
		for (int k = 0; k < 10; k++) begin
			rnd_regs();
			op = (k == 0) ? 8'h80 : 8'($urandom);
			if (k == 0) rv.a[7:0] = 8'h7f;
			run({`CCU_AUG_IMM, 4'h0, op}, cmp(1'b1, sx8(op), sx8(rv.a[7:0])), '0, 2);
		end
		for (int k = 0; k < 24; k++) begin
			rnd_regs();
			mword = 24'($urandom);
			mdly = 4'($urandom_range(5));
			ind = 1'($urandom);
			x = (k % 4 == 0) ? 3'(1 + (k / 4) % 3) : 3'($urandom);
			case (k % 4)
				0: sec = (x == 3'h1) ? rv.i : ((x == 3'h2) ? rv.j : rv.k);
				1: sec = rv.e;
				2: sec = rv.a;
				default: sec = sx8(rv.a[7:0]);
			endcase
			run({6'(`CCU_OPC_MEM_IDX + k % 4), ind, x, 14'($urandom)},
				cmp(1'b1, (k % 4 == 3) ? sx8(mword[7:0]) : mword, sec),
				// word seen mdly+2 edges after take, code written one edge later
				{1'b1, ind, (k % 4 == 0) ? 3'h0 : x, k % 4 != 0}, 4 + mdly);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			i_start <= 1'b1;
			i_instr <= {`CCU_OPC_MEM_IDX, 1'b0, k[0] ? 3'h4 : 3'h0, 14'h0};
			@(posedge i_clk);
			i_start <= 1'b0;
			#1;
			chk("illegal", {o_illegal, o_busy, o_mem_req.req}, 3'b100);
			@(posedge i_clk);
			#1;
			chk("illegal end", {o_illegal, o_cc_we}, 2'b00);
		end
		conclude();
	end
endmodule

`default_nettype wire
